// file: ptd_pkg.sv
// How it works
// [R1] Default: FIFO order, drop only when full
// [R2] Past a threshold, drop its priority
// [R3] Nine thresholds: port plus eight priorities
// [R4] Percent 0..100, sum over 100 refused
// [R5] Sum under 100 accepted as configured
// [R6] Priority thresholds apply to multicast only
// [R7] Priority space used up, drop its frames
// [R8] Priority maps to unicast or multicast class
// [R9] Queue from ports and user priority
// [R10] Untrusted port uses default priority mapping
// [R11] Trusted port takes priority from header
// [R12] Egress rewrites priority, optionally VLAN id
// [R13] Drop storm traffic above maximum rate
// [R14] Optional shutdown and log on storm
// [R15] Port and priority limits bound buffers
// [R16] Percent scaled to bytes of buffer
package ptd_pkg;
  // Core clock and storm sampling window
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned STORM_WIN_MS  = 5000;
  localparam int unsigned STORM_WIN_CYC = STORM_WIN_MS * (CLK_HZ / 1000);
  // Buffer geometry
  localparam int unsigned N_PRIO     = 8;
  localparam int unsigned PCT_W      = 8;
  localparam int unsigned PCT_FULL   = 100;
  localparam int unsigned BUF_BYTES  = 32768;
  localparam int unsigned BYTE_W     = 17;
  localparam int unsigned LEN_W      = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_AW    = 4;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_PTHR   = 8'h04;
  localparam logic [7:0] ADR_PCT_LO = 8'h08;
  localparam logic [7:0] ADR_PCT_HI = 8'h0c;
  localparam logic [7:0] ADR_TCMAP  = 8'h10;
  localparam logic [7:0] ADR_DEFP   = 8'h14;
  localparam logic [7:0] ADR_SMAX   = 8'h18;
  localparam logic [7:0] ADR_STAT   = 8'h1c;
  localparam logic [7:0] ADR_USED   = 8'h20;
  localparam logic [7:0] ADR_DROPS  = 8'h24;
  // Field positions
  localparam int unsigned CTRL_TRUST = 0;
  localparam int unsigned CTRL_STORM = 1;
  localparam int unsigned CTRL_SHUT  = 2;
  localparam int unsigned CTRL_COSEN = 3;
  localparam int unsigned DEFP_VID   = 16;
  localparam int unsigned DEFP_VRW   = 31;
  localparam int unsigned ST_DOWN    = 0;
  localparam int unsigned ST_REFUSED = 1;
  localparam int unsigned ST_CNT     = 8;
  // Reset values
  localparam logic [3:0]  RST_CTRL  = 4'h0;
  localparam logic [16:0] RST_PTHR  = 17'h08000;
  localparam logic [63:0] RST_PCT   = 64'h0c0c_0c0c_0c0c_0c0c;
  localparam logic [23:0] RST_TCMAP = 24'hfac681;
  localparam logic [31:0] RST_DEFP  = 32'h0000_0000;
  localparam logic [31:0] RST_SMAX  = 32'hffff_ffff;
  // One stored frame descriptor
  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic [2:0]       up;
    logic [3:0]       q;
    logic [3:0]       egr;
  } ptd_ent_s;
endpackage

// file: ptd_thr_if.sv
`timescale 1ns/100ps
`default_nettype none
// Threshold set between the admission core and the percent converter
interface ptd_thr_if;
  logic [8*ptd_pkg::PCT_W-1:0]  pct_cand;  // Percent set about to be written
  logic [8*ptd_pkg::PCT_W-1:0]  pct_live;  // Percent set in force
  logic                         cand_ok;   // Candidate set is legal
  logic [8*ptd_pkg::BYTE_W-1:0] thr_bytes; // Live set in bytes
  modport core (output pct_cand, output pct_live, input cand_ok, input thr_bytes);
  modport calc (input pct_cand, input pct_live, output cand_ok, output thr_bytes);
endinterface
`default_nettype wire

// file: ptd_cos_calc.sv
`timescale 1ns/100ps
`default_nettype none
// Percent checking and scaling; purely combinational
module ptd_cos_calc (
  ptd_thr_if.calc thr
);
  logic [10:0] sum;     // Sum of the eight candidate percents
  logic        any_big; // Some single entry above full scale

  // Legality of a candidate set
  always_comb begin
    sum     = '0;
    any_big = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sum     = sum + 11'(thr.pct_cand[i*ptd_pkg::PCT_W +: ptd_pkg::PCT_W]);
      any_big = any_big |
        (thr.pct_cand[i*ptd_pkg::PCT_W +: ptd_pkg::PCT_W] > 8'(ptd_pkg::PCT_FULL));
    end
    // Under full scale is fine; the rest just stays unassigned [R5]
    thr.cand_ok = !any_big && (sum <= 11'(ptd_pkg::PCT_FULL)); // [R4]
  end

  // Scale each live percent to bytes of port buffer
  for (genvar g = 0; g < 8; g++) begin : g_thr
    assign thr.thr_bytes[g*ptd_pkg::BYTE_W +: ptd_pkg::BYTE_W] = ptd_pkg::BYTE_W'(
      (24'(thr.pct_live[g*ptd_pkg::PCT_W +: ptd_pkg::PCT_W]) * 24'(ptd_pkg::BUF_BYTES))
      / 24'(ptd_pkg::PCT_FULL)); // [R16]
  end
endmodule
`default_nettype wire

// file: ptd_admit.sv
`timescale 1ns/100ps
`default_nettype none
// Port ingress admission: priority mapping, tail drop, storm control
module ptd_admit #(
  parameter int unsigned P_STORM_WIN_CYC = ptd_pkg::STORM_WIN_CYC
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_wb_cyc,
  input  wire logic                       i_wb_stb,
  input  wire logic                       i_wb_we,
  input  wire logic [7:0]                 i_wb_adr,
  input  wire logic [3:0]                 i_wb_sel,
  input  wire logic [31:0]                i_wb_dat,
  output logic      [31:0]                o_wb_dat,
  output logic                            o_wb_ack,
  input  wire logic                       i_frm_valid,
  input  wire logic [ptd_pkg::LEN_W-1:0]  i_frm_len,
  input  wire logic [2:0]                 i_frm_cos,
  input  wire logic                       i_frm_mcast,
  input  wire logic                       i_frm_storm_traffic,
  input  wire logic [3:0]                 i_frm_egr,
  output logic                            o_adm_valid,
  output logic                            o_adm_drop,
  output logic      [3:0]                 o_adm_queue,
  output logic      [2:0]                 o_adm_up,
  output logic                            o_deq_valid,
  input  wire logic                       i_deq_ready,
  output logic      [ptd_pkg::LEN_W-1:0]  o_deq_len,
  output logic      [3:0]                 o_deq_queue,
  output logic      [3:0]                 o_deq_egr,
  output logic      [2:0]                 o_deq_cos,
  output logic      [11:0]                o_deq_vid,
  output logic                            o_deq_vid_rw,
  output logic                            o_port_down,
  output logic                            o_log_evt
);
  ptd_thr_if thr ();

  // Software state
  logic [3:0]              ctrl_r, ctrl_nxt;       // Trust, storm, shutdown, per-priority
  logic [16:0]             pthr_r, pthr_nxt;       // Port tail-drop limit in bytes
  logic [63:0]             pct_r, pct_nxt;         // Eight per-priority percents
  logic [23:0]             tcmap_r, tcmap_nxt;     // User priority to class
  logic [31:0]             defp_r, defp_nxt;       // Default priority and VLAN rewrite
  logic [31:0]             smax_r, smax_nxt;       // Storm bytes allowed per window
  logic                    down_r, down_nxt;       // Port shut by storm
  logic                    refd_r, refd_nxt;       // A percent write was refused
  logic                    ack_r, ack_nxt;         // Bus answer
  logic [31:0]             rdat_r, rdat_nxt;       // Bus read data
  logic [31:0]             drops_r, drops_nxt;     // Dropped frame count
  // Admission state
  logic [31:0]             win_r, win_nxt;         // Storm window position
  logic [32:0]             scnt_r, scnt_nxt;       // Storm bytes in window
  logic [16:0]             used_r, used_nxt;       // Port bytes queued
  logic [16:0]             pu_r [8];               // Multicast bytes per priority
  logic [16:0]             pu_nxt [8];
  ptd_pkg::ptd_ent_s       mem [ptd_pkg::FIFO_DEPTH]; // Descriptor store
  logic [3:0]              wp_r, wp_nxt, rp_r, rp_nxt;
  logic [4:0]              cnt_r, cnt_nxt;
  logic                    av_r, av_nxt, ad_r, ad_nxt, log_r, log_nxt;
  logic [3:0]              aq_r, aq_nxt;
  logic [2:0]              aup_r, aup_nxt;
  // Decode and decision terms
  logic                    wr, rd, full, deq, acc, win_end;
  logic                    port_over, prio_over, storm_over;
  logic [2:0]              up, tc;
  logic [16:0]             pthr_b;
  ptd_pkg::ptd_ent_s       head;

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      r[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
    return r;
  endfunction

  ptd_cos_calc u_calc (
    .thr (thr)
  );

  // Write takes effect at the edge that raises ack
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_r;
  assign rd = i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack_r;

  // Candidate percents: the live set with this write folded in
  always_comb begin
    thr.pct_cand = pct_r;
    if (wr && i_wb_adr == ptd_pkg::ADR_PCT_LO) begin
      thr.pct_cand[31:0] = wmerge(pct_r[31:0], i_wb_dat, i_wb_sel);
    end else if (wr && i_wb_adr == ptd_pkg::ADR_PCT_HI) begin
      thr.pct_cand[63:32] = wmerge(pct_r[63:32], i_wb_dat, i_wb_sel);
    end
  end
  assign thr.pct_live = pct_r;

  // Priority mapping and queue choice
  always_comb begin
    up   = ctrl_r[ptd_pkg::CTRL_TRUST] ? i_frm_cos : defp_r[2:0]; // [R11] [R10]
    tc   = tcmap_r[up*3 +: 3];                                   // [R8]
    head = mem[rp_r];
  end

  // Admission decision, one descriptor per cycle
  always_comb begin
    full    = (cnt_r == 5'(ptd_pkg::FIFO_DEPTH));
    deq     = (cnt_r != 5'h00) & i_deq_ready;
    win_end = (win_r == 32'(P_STORM_WIN_CYC - 1));
    pthr_b  = (pthr_r > 17'(ptd_pkg::BUF_BYTES)) ? 17'(ptd_pkg::BUF_BYTES) : pthr_r;
    // Port limit and total memory both bound the port [R15] [R1]
    port_over  = (18'(used_r) + 18'(i_frm_len)) > 18'(pthr_b);
    // Multicast only, against the scaled per-priority limit [R6] [R7] [R2] [R15]
    prio_over  = i_frm_mcast & ctrl_r[ptd_pkg::CTRL_COSEN] &
                 ((18'(pu_r[up]) + 18'(i_frm_len)) >
                  18'(thr.thr_bytes[up*ptd_pkg::BYTE_W +: ptd_pkg::BYTE_W]));
    storm_over = i_frm_storm_traffic & ctrl_r[ptd_pkg::CTRL_STORM] &
                 ((scnt_r + 33'(i_frm_len)) > 33'(smax_r)); // [R13]
    acc = i_frm_valid & ~down_r & ~full & ~port_over & ~prio_over & ~storm_over;
  end

  // Registers, status flags and bus answer
  always_comb begin
    ctrl_nxt  = ctrl_r;
    pthr_nxt  = pthr_r;
    pct_nxt   = pct_r;
    tcmap_nxt = tcmap_r;
    defp_nxt  = defp_r;
    smax_nxt  = smax_r;
    down_nxt  = down_r;
    refd_nxt  = refd_r;
    ack_nxt   = i_wb_cyc & i_wb_stb & ~ack_r;
    rdat_nxt  = rdat_r;
    if (wr) begin
      unique case (i_wb_adr)
        ptd_pkg::ADR_CTRL: begin
          ctrl_nxt = 4'(wmerge({28'h0, ctrl_r}, i_wb_dat, i_wb_sel));
        end
        ptd_pkg::ADR_PTHR: begin
          pthr_nxt = 17'(wmerge({15'h0, pthr_r}, i_wb_dat, i_wb_sel));
        end
        ptd_pkg::ADR_PCT_LO, ptd_pkg::ADR_PCT_HI: begin
          // Whole set is refused if it breaks the percent budget [R4] [R5]
          if (thr.cand_ok) begin
            pct_nxt = thr.pct_cand;
          end else begin
            refd_nxt = 1'b1;
          end
        end
        ptd_pkg::ADR_TCMAP: begin
          tcmap_nxt = 24'(wmerge({8'h0, tcmap_r}, i_wb_dat, i_wb_sel));
        end
        ptd_pkg::ADR_DEFP: begin
          defp_nxt = wmerge(defp_r, i_wb_dat, i_wb_sel);
        end
        ptd_pkg::ADR_SMAX: begin
          smax_nxt = wmerge(smax_r, i_wb_dat, i_wb_sel);
        end
        ptd_pkg::ADR_STAT: begin
          // Write one to clear; a fresh set below still wins
          if (i_wb_sel[0] && i_wb_dat[ptd_pkg::ST_DOWN]) begin
            down_nxt = 1'b0;
          end
          if (i_wb_sel[0] && i_wb_dat[ptd_pkg::ST_REFUSED]) begin
            refd_nxt = 1'b0;
          end
        end
        default: begin
          // Read-only or unmapped: write ignored, still answered
        end
      endcase
    end
    // Storm with shutdown enabled takes the port down [R14]
    if (i_frm_valid && storm_over && ctrl_r[ptd_pkg::CTRL_SHUT]) begin
      down_nxt = 1'b1;
    end
    if (rd) begin
      unique case (i_wb_adr)
        ptd_pkg::ADR_CTRL:   rdat_nxt = {28'h0, ctrl_r};
        ptd_pkg::ADR_PTHR:   rdat_nxt = {15'h0, pthr_r};
        ptd_pkg::ADR_PCT_LO: rdat_nxt = pct_r[31:0];
        ptd_pkg::ADR_PCT_HI: rdat_nxt = pct_r[63:32];
        ptd_pkg::ADR_TCMAP:  rdat_nxt = {8'h0, tcmap_r};
        ptd_pkg::ADR_DEFP:   rdat_nxt = defp_r;
        ptd_pkg::ADR_SMAX:   rdat_nxt = smax_r;
        ptd_pkg::ADR_STAT:   rdat_nxt = {19'h0, cnt_r, 6'h00, refd_r, down_r};
        ptd_pkg::ADR_USED:   rdat_nxt = {15'h0, used_r};
        ptd_pkg::ADR_DROPS:  rdat_nxt = drops_r;
        default:             rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Queue state, storm window and admission result
  always_comb begin
    wp_nxt    = acc ? wp_r + 4'h1 : wp_r;                 // [R1]
    rp_nxt    = deq ? rp_r + 4'h1 : rp_r;
    cnt_nxt   = cnt_r + {4'h0, acc} - {4'h0, deq};
    used_nxt  = used_r + (acc ? 17'(i_frm_len) : 17'h0)
                       - (deq ? 17'(head.len) : 17'h0);   // [R3] [R15]
    win_nxt   = win_end ? 32'h0 : win_r + 32'h1;          // [R14]
    // Only admitted storm bytes count toward the rate
    scnt_nxt  = (win_end ? 33'h0 : scnt_r) +
                ((acc & i_frm_storm_traffic) ? 33'(i_frm_len) : 33'h0);
    av_nxt    = i_frm_valid;
    ad_nxt    = i_frm_valid & ~acc;
    aq_nxt    = {i_frm_mcast, tc};                        // [R8] [R9]
    aup_nxt   = up;
    log_nxt   = i_frm_valid & storm_over & ctrl_r[ptd_pkg::CTRL_SHUT] & ~down_r; // [R14]
    drops_nxt = drops_r + {31'h0, ad_nxt};
  end

  // Per-priority multicast occupancy
  for (genvar g = 0; g < 8; g++) begin : g_pu
    always_comb begin
      pu_nxt[g] = pu_r[g]
        + ((acc && i_frm_mcast && up == 3'(g)) ? 17'(i_frm_len) : 17'h0)
        - ((deq && head.q[3] && head.up == 3'(g)) ? 17'(head.len) : 17'h0); // [R7]
    end
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        pu_r[g] <= 17'h0;
      end else begin
        pu_r[g] <= pu_nxt[g];
      end
    end
  end

  // Descriptor store; contents need no reset
  always_ff @(posedge i_core_clk) begin
    if (acc) begin
      mem[wp_r] <= '{len: i_frm_len, up: up, q: aq_nxt, egr: i_frm_egr}; // [R9]
    end
  end

  // All other state
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_r  <= ptd_pkg::RST_CTRL;
      pthr_r  <= ptd_pkg::RST_PTHR;
      pct_r   <= ptd_pkg::RST_PCT;
      tcmap_r <= ptd_pkg::RST_TCMAP;
      defp_r  <= ptd_pkg::RST_DEFP;
      smax_r  <= ptd_pkg::RST_SMAX;
      down_r  <= 1'b0;
      refd_r  <= 1'b0;
      ack_r   <= 1'b0;
      rdat_r  <= 32'h0000_0000;
      drops_r <= 32'h0000_0000;
      win_r   <= 32'h0000_0000;
      scnt_r  <= 33'h0;
      used_r  <= 17'h0;
      wp_r    <= 4'h0;
      rp_r    <= 4'h0;
      cnt_r   <= 5'h00;
      av_r    <= 1'b0;
      ad_r    <= 1'b0;
      aq_r    <= 4'h0;
      aup_r   <= 3'h0;
      log_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      pthr_r  <= pthr_nxt;
      pct_r   <= pct_nxt;
      tcmap_r <= tcmap_nxt;
      defp_r  <= defp_nxt;
      smax_r  <= smax_nxt;
      down_r  <= down_nxt;
      refd_r  <= refd_nxt;
      ack_r   <= ack_nxt;
      rdat_r  <= rdat_nxt;
      drops_r <= drops_nxt;
      win_r   <= win_nxt;
      scnt_r  <= scnt_nxt;
      used_r  <= used_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      av_r    <= av_nxt;
      ad_r    <= ad_nxt;
      aq_r    <= aq_nxt;
      aup_r   <= aup_nxt;
      log_r   <= log_nxt;
    end
  end

  // Outputs; egress priority is the derived user priority [R12]
  assign o_wb_dat     = rdat_r;
  assign o_wb_ack     = ack_r;
  assign o_adm_valid  = av_r;
  assign o_adm_drop   = ad_r;
  assign o_adm_queue  = aq_r;
  assign o_adm_up     = aup_r;
  assign o_deq_valid  = (cnt_r != 5'h00);
  assign o_deq_len    = head.len;
  assign o_deq_queue  = head.q;
  assign o_deq_egr    = head.egr;
  assign o_deq_cos    = head.up;                     // [R12]
  assign o_deq_vid    = defp_r[ptd_pkg::DEFP_VID +: 12];
  assign o_deq_vid_rw = defp_r[ptd_pkg::DEFP_VRW];   // [R12]
  assign o_port_down  = down_r;
  assign o_log_evt    = log_r;

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_NO_OVERFILL: assert property (used_r <= 17'(ptd_pkg::BUF_BYTES)) // [R1]
    else $error("Port buffer overfilled");
  AST_FULL_DROP: assert property (i_frm_valid && full |=> o_adm_valid && o_adm_drop) // [R1]
    else $error("Frame kept with descriptor store full");
  AST_PORT_LIMIT: assert property (i_frm_valid && port_over |=> o_adm_drop) // [R15]
    else $error("Frame kept past port limit");
  AST_PRIO_DROP: assert property (i_frm_valid && prio_over |=> o_adm_drop) // [R7]
    else $error("Multicast kept past priority limit");
  AST_UCAST_FREE: assert property (o_adm_drop && !$past(i_frm_mcast) |->
    $past(down_r || full || port_over || storm_over)) // [R6]
    else $error("Unicast dropped by priority limit");
  AST_TRUST_UP: assert property (i_frm_valid && ctrl_r[ptd_pkg::CTRL_TRUST] |=>
    o_adm_up == $past(i_frm_cos)) // [R11]
    else $error("Trusted priority not taken from header");
  AST_DEF_UP: assert property (i_frm_valid && !ctrl_r[ptd_pkg::CTRL_TRUST] |=>
    o_adm_up == $past(defp_r[2:0])) // [R10]
    else $error("Untrusted priority not default");
  AST_REFUSE: assert property (wr && !thr.cand_ok && (i_wb_adr == ptd_pkg::ADR_PCT_LO ||
    i_wb_adr == ptd_pkg::ADR_PCT_HI) |=> $stable(pct_r) && refd_r) // [R4]
    else $error("Over-budget percent set applied");
  AST_STORM_DROP: assert property (i_frm_valid && storm_over |=> o_adm_drop) // [R13]
    else $error("Storm frame kept over rate");
  AST_STORM_SHUT: assert property (i_frm_valid && storm_over && ctrl_r[ptd_pkg::CTRL_SHUT]
    && !down_r |=> o_port_down && o_log_evt ##1 !o_log_evt) // [R14]
    else $error("Storm shutdown or log missing");
  AST_QSEL: assert property (o_adm_valid |-> o_adm_queue[3] == $past(i_frm_mcast)) // [R8]
    else $error("Queue family wrong");

  COV_ACCEPT: cover property (i_frm_valid && acc ##1 o_deq_valid);
  COV_PRIO: cover property (i_frm_valid && prio_over && !port_over);
  COV_SHUT: cover property (o_log_evt);
  COV_REFUSE: cover property (wr && !thr.cand_ok);
endmodule
`default_nettype wire

// file: ptd_nbr_model.sv
`timescale 1ns/100ps
`default_nettype none
// Neighbouring Ethernet device: sends frame descriptors and drains the queue
module ptd_nbr_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rdy_mode,
  output logic             o_frm_valid,
  output logic      [15:0] o_frm_len,
  output logic      [2:0]  o_frm_cos,
  output logic             o_frm_mcast,
  output logic             o_frm_storm_traffic,
  output logic      [3:0]  o_frm_egr,
  output logic             o_deq_ready
);
  // Quiet line at time zero
  initial begin
    o_frm_valid = 1'b0;
    {o_frm_len, o_frm_cos, o_frm_mcast, o_frm_storm_traffic, o_frm_egr} = '0;
    o_deq_ready = 1'b0;
  end
  // Ready is redrawn each cycle so the queue sees real stalls; mode 0 stalls
  always @(posedge i_core_clk) begin
    o_deq_ready <= i_rdy_mode & ($urandom_range(0, 3) != 0);
  end
  // One descriptor per call; fields are scrambled once valid falls
  task automatic send(input logic [15:0] l, input logic [2:0] c, input logic m,
                      input logic s, input logic [3:0] e);
    @(posedge i_core_clk);
    o_frm_valid <= 1'b1;
    {o_frm_len, o_frm_cos, o_frm_mcast, o_frm_storm_traffic, o_frm_egr} <= {l, c, m, s, e};
    @(posedge i_core_clk);
    o_frm_valid <= 1'b0;
    {o_frm_len, o_frm_cos, o_frm_mcast, o_frm_storm_traffic, o_frm_egr} <= ~{l, c, m, s, e};
  endtask
endmodule
`default_nettype wire

// file: priority_queue_tail_drop_admission_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the port admission block
module priority_queue_tail_drop_admission_tb_top;
  logic        i_core_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, rdy;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel, wsel;  // wsel: byte lanes of the next request
  logic [31:0] i_wb_dat, o_wb_dat;
  logic        i_frm_valid, i_frm_mcast, i_frm_storm_traffic, i_deq_ready;
  logic [15:0] i_frm_len, o_deq_len;
  logic [2:0]  i_frm_cos, o_adm_up, o_deq_cos;
  logic [3:0]  i_frm_egr, o_adm_queue, o_deq_queue, o_deq_egr;
  logic        o_adm_valid, o_adm_drop, o_deq_valid, o_deq_vid_rw, o_port_down, o_log_evt;
  logic [11:0] o_deq_vid;
  logic [26:0] exp_q[$];  // Admitted frames in arrival order
  int          fail_count, cmp_count, cyc_n, log_n;
  localparam logic [23:0] TCM = ptd_pkg::RST_TCMAP;
  // Register map probe table: address and reset value, last one unmapped
  localparam logic [7:0]  RA[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h30};
  localparam logic [31:0] RV[8] = '{32'h0, 32'h8000, 32'h0c0c0c0c, 32'h0c0c0c0c,
                                    32'hfac681, 32'h0, 32'hffffffff, 32'h0};

  ptd_admit #(.P_STORM_WIN_CYC(64)) DUT (
    .i_core_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .i_frm_valid, .i_frm_len, .i_frm_cos, .i_frm_mcast,
    .i_frm_storm_traffic, .i_frm_egr, .o_adm_valid, .o_adm_drop, .o_adm_queue, .o_adm_up,
    .o_deq_valid, .i_deq_ready, .o_deq_len, .o_deq_queue, .o_deq_egr, .o_deq_cos,
    .o_deq_vid, .o_deq_vid_rw, .o_port_down, .o_log_evt
  );
  ptd_nbr_model nbr (
    .i_core_clk, .i_rdy_mode(rdy), .o_frm_valid(i_frm_valid), .o_frm_len(i_frm_len),
    .o_frm_cos(i_frm_cos), .o_frm_mcast(i_frm_mcast), .o_frm_storm_traffic(i_frm_storm_traffic),
    .o_frm_egr(i_frm_egr), .o_deq_ready(i_deq_ready)
  );

  // 20 MHz clock
  always #25 i_core_clk = ~i_core_clk;

  // Mismatch reporting, one task per kind of result
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_frm(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t frame got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Closing report, also reached from the hang guard
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Classic single cycle; request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge i_core_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_sel, i_wb_adr, i_wb_dat} <= {2'b11, w, wsel, a, d};
    do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask
  // Expected queue: multicast flag over the class mapped from the priority
  function automatic logic [3:0] q_of(input logic m, input logic [2:0] u);
    return {m, TCM[3*u +: 3]};
  endfunction
  // Send one frame and check the admission verdict a cycle later
  task automatic snd(input logic [15:0] l, input logic [2:0] c, input logic m,
                     input logic s, input logic [2:0] u, input logic dr);
    logic [3:0] e;
    e = 4'($urandom);
    nbr.send(l, c, m, s, e);
    #1;
    chk_frm(32'({o_adm_valid, o_adm_drop, dr ? 7'h0 : {o_adm_queue, o_adm_up}}),
            32'({1'b1, dr, dr ? 7'h0 : {q_of(m, u), u}}));
    if (!dr) exp_q.push_back({l, q_of(m, u), e, u});
  endtask
  // Let the neighbour drain everything; the hang guard bounds the wait
  task automatic drain;
    rdy <= 1'b1;
    do @(posedge i_core_clk); while (o_deq_valid !== 1'b0);
    chk_reg(32'(exp_q.size()), 32'h0);
  endtask

  // Dequeue watcher and hang guard; stored frames leave in arrival order
  always @(posedge i_core_clk) begin
    cyc_n <= cyc_n + 1;
    if (o_log_evt === 1'b1) log_n <= log_n + 1;
    if (o_deq_valid === 1'b1 && i_deq_ready === 1'b1)
      chk_frm(32'({o_deq_len, o_deq_queue, o_deq_egr, o_deq_cos}),
              32'(exp_q.size() ? exp_q.pop_front() : 'x));
    if (cyc_n == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] d;
    logic [2:0]  c;
    logic        m;
    {i_core_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, rdy} = 6'b010000;
    {i_wb_adr, i_wb_dat, i_wb_sel} = {8'h0, 32'h0, 4'hf};
    wsel = 4'hf;
    {fail_count, cmp_count, cyc_n, log_n} = '0;
    d = $urandom(32'h5d183f86);
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // Reset values and an unmapped hole
    foreach (RA[k]) begin
      wb(1'b0, RA[k], 32'h0, d);
      chk_reg(d, RV[k]);
    end
    // Untrusted port takes the default priority; VLAN rewrite shows at the head
    wb(1'b1, 8'h14, 32'h8abc_0005, d);
    snd(16'd100, 3'd2, 1'b0, 1'b0, 3'd5, 1'b0);
    snd(16'd200, 3'd6, 1'b1, 1'b0, 3'd5, 1'b0);
    chk_reg(32'({o_deq_vid_rw, o_deq_vid}), 32'h1abc);
    drain();
    // Trusted port: header priority, random mix with a stalling consumer
    wb(1'b1, 8'h00, 32'h1, d);
    for (int k = 0; k < 12; k++) begin
      c = 3'($urandom);
      m = 1'($urandom);
      snd(16'($urandom_range(64, 1500)), c, m, 1'b0, c, 1'b0);
    end
    drain();
    // Sixteen descriptors fill the store; the seventeenth finds no room
    rdy <= 1'b0;
    for (int k = 0; k < 17; k++) snd(16'd64, 3'(k), 1'b0, 1'b0, 3'(k), k == 16);
    wb(1'b0, 8'h1c, 32'h0, d);
    chk_reg(d & 32'h1f00, 32'h1000);
    drain();
    // Port limit 1000: exactly reaching it is allowed, passing it is not
    rdy <= 1'b0;
    wb(1'b1, 8'h04, 32'd1000, d);
    for (int k = 0; k < 4; k++) snd(16'd300, 3'd1, 1'b0, 1'b0, 3'd1, k == 3);
    snd(16'd100, 3'd1, 1'b0, 1'b0, 3'd1, 1'b0);
    wb(1'b0, 8'h20, 32'h0, d);
    chk_reg(d, 32'd1000);
    drain();
    wb(1'b1, 8'h04, 32'h8000, d);
    // Priority 0 at 1 percent is 327 bytes of 32768; sum 85 is accepted
    rdy <= 1'b0;
    wb(1'b1, 8'h08, 32'h0c0c0c01, d);
    wb(1'b1, 8'h00, 32'h9, d);
    snd(16'd300, 3'd0, 1'b1, 1'b0, 3'd0, 1'b0);
    snd(16'd28, 3'd0, 1'b1, 1'b0, 3'd0, 1'b1);
    snd(16'd27, 3'd0, 1'b1, 1'b0, 3'd0, 1'b0);
    snd(16'd100, 3'd0, 1'b0, 1'b0, 3'd0, 1'b0);
    snd(16'd1000, 3'd1, 1'b1, 1'b0, 3'd1, 1'b0);
    drain();
    // A set summing to 237 and a byte of 101 are refused; a sum of exactly 100 is taken
    wb(1'b1, 8'h0c, 32'h3232_3232, d);
    wb(1'b0, 8'h0c, 32'h0, d);
    chk_reg(d, 32'h0c0c0c0c);
    wb(1'b0, 8'h1c, 32'h0, d);
    chk_reg(d & 32'h2, 32'h2);
    wb(1'b1, 8'h1c, 32'h2, d);
    wb(1'b1, 8'h08, 32'h0000_0065, d);
    wb(1'b0, 8'h08, 32'h0, d);
    chk_reg(d, 32'h0c0c0c01);
    wb(1'b1, 8'h1c, 32'h2, d);
    wb(1'b1, 8'h08, 32'h0000_0034, d);
    wb(1'b0, 8'h08, 32'h0, d);
    chk_reg(d, 32'h34);
    // One lane written: the merged set sums to 105 and must be refused
    wsel = 4'h2;
    wb(1'b1, 8'h08, 32'h0000_0500, d);
    wsel = 4'hf;
    wb(1'b0, 8'h08, 32'h0, d);
    chk_reg(d, 32'h34);
    // Storm limit 500: over-rate storm frame dropped, others pass
    rdy <= 1'b1;
    wb(1'b1, 8'h18, 32'd500, d);
    wb(1'b1, 8'h00, 32'h3, d);
    snd(16'd600, 3'd1, 1'b0, 1'b1, 3'd1, 1'b1);
    snd(16'd600, 3'd1, 1'b0, 1'b0, 3'd1, 1'b0);
    snd(16'd400, 3'd1, 1'b1, 1'b1, 3'd1, 1'b0);
    chk_reg(32'({o_port_down, 4'(log_n)}), 32'h0);
    // With shutdown on, the same breach takes the port down and logs once
    wb(1'b1, 8'h00, 32'h7, d);
    snd(16'd600, 3'd2, 1'b0, 1'b1, 3'd2, 1'b1);
    snd(16'd64, 3'd2, 1'b0, 1'b0, 3'd2, 1'b1);
    wb(1'b0, 8'h1c, 32'h0, d);
    chk_reg(32'({d[0], o_port_down, 4'(log_n)}), 32'h31);
    drain();
    // Six drops in all: full store, port limit, priority limit, two storm, one with the port down
    wb(1'b0, 8'h24, 32'h0, d);
    chk_reg(d, 32'd6);
    wrap_up();
  end
endmodule
`default_nettype wire
